/* File: logic/sfc_strobe_ctrl.sv */
// How it works
// - Strobe off while enable is 0; writing 1 arms.
// - Polarity 0 gives positive pulse, 1 negative pulse.
// - Xenon pulse lasts width field plus one lines.
// - Mode 00 xenon, 01/10 LED 1-2, 11 LED 3.
// - Serial write request drives strobe to active level.
// - Single pulse for xenon and LED 1-2; LED 3 continuous.
// - Strobe pin drives only when direction bit is 1.
// - Hard or soft reset restores strobe control default.
`timescale 1ns/10ps
`include "sfc_params.svh"
module sfc_strobe_ctrl #(
  parameter int LINE_W = 3,
  parameter int LED_PULSE_LINES = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input sfc_pkg::sfc_reg_req_t reg_req_in,
  input wire logic line_tick_in,
  output logic [7:0] reg_rdata_out,
  output logic strobe_out,
  output logic strobe_oe_out
);
  import sfc_pkg::*;

  sfc_ctrl_t ctrl_q;
  sfc_ctrl_t ctrl_d;
  logic [7:0] iodir_q;
  logic [7:0] iodir_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  sfc_state_t state_q;
  sfc_state_t state_d;
  logic strobe_q;
  logic strobe_d;
  logic oe_q;
  logic oe_d;
  logic soft_rst;
  logic ctrl_wr;
  logic timer_load;
  logic timer_clear;
  logic timer_expire;
  logic [LINE_W-1:0] pulse_len;

  ////////////////////////////////////////////////////////////////////////
  // Register decode. Soft reset is a strobe, so its register reads zero.
  always_comb
  begin
    soft_rst = reg_req_in.wr && (reg_req_in.addr == `SFC_ADDR_SYSRST) && reg_req_in.wdata[`SFC_SOFTRST_BIT];
    ctrl_wr = reg_req_in.wr && (reg_req_in.addr == `SFC_ADDR_CTRL);
    ctrl_d = ctrl_q;
    iodir_d = iodir_q;
    rdata_d = rdata_q;
    if (ctrl_wr)
    begin
      ctrl_d = sfc_ctrl_t'(reg_req_in.wdata & `SFC_CTRL_WMASK); // Reserved bits stay zero.
    end
    if (reg_req_in.wr && (reg_req_in.addr == `SFC_ADDR_IODIR))
    begin
      iodir_d = reg_req_in.wdata;
    end
    if (soft_rst)
    begin
      ctrl_d = sfc_ctrl_t'(`SFC_CTRL_RESET);
    end
    if (reg_req_in.rd)
    begin
      if (reg_req_in.addr == `SFC_ADDR_CTRL)
      begin
        rdata_d = ctrl_q;
      end
      else if (reg_req_in.addr == `SFC_ADDR_IODIR)
      begin
        rdata_d = iodir_q;
      end
      else
      begin
        rdata_d = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse length in lines; LED 1-2 uses a fixed length.
  always_comb
  begin
    if (ctrl_d.mode == `SFC_MODE_XENON)
    begin
      pulse_len = LINE_W'(ctrl_d.width) + LINE_W'(1);
    end
    else
    begin
      pulse_len = LINE_W'(LED_PULSE_LINES);
    end
  end

  // Strobe sequencer. A write while a pulse runs does not retrigger it.
  always_comb
  begin
    state_d = state_q;
    timer_load = 1'b0;
    timer_clear = 1'b0;
    if (soft_rst || !ctrl_d.enable)
    begin
      state_d = SFC_IDLE;
      timer_clear = 1'b1;
    end
    else
    begin
      unique case (state_q)
        SFC_IDLE:
        begin
          if (ctrl_wr)
          begin
            if (ctrl_d.mode == `SFC_MODE_LED3)
            begin
              state_d = SFC_HOLD;
            end
            else
            begin
              state_d = SFC_PULSE;
              timer_load = 1'b1;
            end
          end
        end
        SFC_PULSE:
        begin
          if (timer_expire)
          begin
            state_d = SFC_IDLE;
          end
        end
        SFC_HOLD:
        begin
          if (ctrl_d.mode != `SFC_MODE_LED3)
          begin
            state_d = SFC_IDLE;
          end
        end
        default:
        begin
          state_d = SFC_IDLE;
        end
      endcase
    end
    // Registered from the next state so the pin moves with the state itself.
    strobe_d = (state_d != SFC_IDLE) ^ ctrl_d.polarity;
    oe_d = iodir_d[`SFC_IODIR_STROBE_BIT];
  end

  sfc_line_timer #(
    .W(LINE_W)
  ) u_timer (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .load_in(timer_load),
    .clear_in(timer_clear),
    .load_val_in(pulse_len),
    .tick_in(line_tick_in),
    .busy_out(),
    .expire_out(timer_expire)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registers only; hard reset returns every field to default.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      ctrl_q <= sfc_ctrl_t'(`SFC_CTRL_RESET);
      iodir_q <= `SFC_IODIR_RESET;
      rdata_q <= 8'h00;
      state_q <= SFC_IDLE;
      strobe_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      iodir_q <= iodir_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      strobe_q <= strobe_d;
      oe_q <= oe_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign strobe_out = strobe_q;
  assign strobe_oe_out = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Checking helpers: independent count of lines seen in a pulse.
  logic [LINE_W-1:0] chk_ticks_q;
  logic [LINE_W-1:0] chk_len_q;
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || state_q != SFC_PULSE)
    begin
      chk_ticks_q <= '0;
    end
    else if (line_tick_in)
    begin
      chk_ticks_q <= chk_ticks_q + LINE_W'(1);
    end
    if (!rstn_in)
    begin
      chk_len_q <= '0;
    end
    else if (timer_load)
    begin
      chk_len_q <= pulse_len;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_level_polarity: assert property (strobe_out == ((state_q != SFC_IDLE) ^ ctrl_q.polarity))
    else $error("strobe level does not match state and polarity");
  a_off_disabled: assert property (!ctrl_q.enable |-> state_q == SFC_IDLE)
    else $error("strobe active while disabled");
  a_write_arms: assert property ((ctrl_wr && reg_req_in.wdata[7] && !soft_rst && state_q == SFC_IDLE)
    |=> (state_q != SFC_IDLE) && (strobe_out == !ctrl_q.polarity))
    else $error("enable write did not drive strobe active");
  a_pulse_short: assert property (state_q == SFC_PULSE |-> chk_ticks_q < chk_len_q)
    else $error("strobe pulse longer than programmed lines");
  a_pulse_ends: assert property ((state_q == SFC_PULSE && line_tick_in && chk_ticks_q == chk_len_q - LINE_W'(1))
    |=> state_q == SFC_IDLE)
    else $error("strobe pulse did not end on its last line");
  a_xenon_len: assert property ((timer_load && ctrl_d.mode == `SFC_MODE_XENON)
    |-> pulse_len == LINE_W'(ctrl_d.width) + LINE_W'(1))
    else $error("xenon pulse length wrong");
  a_hold_mode: assert property (state_q == SFC_HOLD |-> ctrl_q.mode == `SFC_MODE_LED3)
    else $error("continuous hold outside LED 3 mode");
  a_hold_stays: assert property ((state_q == SFC_HOLD && !reg_req_in.wr) |=> state_q == SFC_HOLD)
    else $error("LED 3 hold dropped without a write");
  a_pin_dir: assert property (##1 strobe_oe_out == $past(iodir_d[`SFC_IODIR_STROBE_BIT]))
    else $error("strobe drive enable does not follow direction bit");
  a_soft_reset: assert property (soft_rst |=> ctrl_q == sfc_ctrl_t'(`SFC_CTRL_RESET) && state_q == SFC_IDLE)
    else $error("soft reset did not restore strobe control");

  c_xenon_pulse: cover property ((state_q == SFC_IDLE) ##1 (state_q == SFC_PULSE)[*2] ##1 (state_q == SFC_IDLE));
  c_led3_hold: cover property ((state_q == SFC_HOLD)[*4]);
  c_negative_pulse: cover property (state_q == SFC_PULSE && ctrl_q.polarity && !strobe_out);
  c_soft_reset_busy: cover property (soft_rst && state_q != SFC_IDLE);
endmodule

/* File: logic/sfc_params.svh */
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
// Register addresses on the serial control port.
`define SFC_ADDR_CTRL 16'h307A
`define SFC_ADDR_IODIR 16'h30B1
`define SFC_ADDR_SYSRST 16'h3012
// Field positions.
`define SFC_SOFTRST_BIT 7
`define SFC_IODIR_STROBE_BIT 4
// Reset values and write masks.
`define SFC_CTRL_RESET 8'h00
`define SFC_IODIR_RESET 8'h00
`define SFC_CTRL_WMASK 8'hCF
// Mode codes.
`define SFC_MODE_XENON 2'h0
`define SFC_MODE_LED3 2'h3
`endif

/* File: logic/sfc_pkg.sv */
package sfc_pkg;
  // Strobe control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic enable;
    logic polarity;
    logic [1:0] rsvd;
    logic [1:0] width;
    logic [1:0] mode;
  } sfc_ctrl_t;
  // One register access from the serial control port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sfc_reg_req_t;
  typedef enum logic [2:0] {
    SFC_IDLE = 3'b001,
    SFC_PULSE = 3'b010,
    SFC_HOLD = 3'b100
  } sfc_state_t;
endpackage

/* File: logic/sfc_line_timer.sv */
`timescale 1ns/10ps
module sfc_line_timer #(
  parameter int W = 3
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic clear_in,
  input wire logic [W-1:0] load_val_in,
  input wire logic tick_in,
  output logic busy_out,
  output logic expire_out
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;

  ////////////////////////////////////////////////////////////////////////
  // Counts line ticks down; the tick in the load cycle is not counted.
  always_comb
  begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    expire_out = busy_q && tick_in && (cnt_q == W'(1));
    if (clear_in)
    begin
      busy_d = 1'b0;
      cnt_d = '0;
    end
    else if (load_in)
    begin
      busy_d = 1'b1;
      cnt_d = load_val_in;
    end
    else if (busy_q && tick_in)
    begin
      cnt_d = cnt_q - W'(1);
      busy_d = !expire_out;
    end
  end

  // Registers only.
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy_out = busy_q;
endmodule

/* File: tb/sfc_flash_model.sv */
`timescale 1ns/10ps
// Flash unit seen from the strobe pin; it counts the triggers it receives.
module sfc_flash_model (
  input wire logic clk_in,
  input wire logic pin_in,
  input wire logic pol_in,
  output int fires_out
);
  logic last_q = 1'b0;
  initial fires_out = 0;
  // Sampled on the clock so that a glitch between edges never triggers.
  always @(posedge clk_in)
  begin
    if (pin_in !== last_q && pin_in === !pol_in)
    begin
      fires_out <= fires_out + 1;
    end
    last_q <= pin_in;
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import sfc_pkg::*;
  localparam int LEDN = 2;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  sfc_reg_req_t req = '0;
  logic tick = 1'b0;
  logic pol = 1'b0;
  logic [7:0] rdata;
  logic strobe;
  logic oe;
  logic pin;
  int fires;
  int err_total = 0;
  int total_checks = 0;
  int seed = 58;
  // LED pulse made two lines long so it differs from the shortest xenon one.
  sfc_strobe_ctrl #(.LED_PULSE_LINES(LEDN)) sfc_strobe_ctrl_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_req_in(req), .line_tick_in(tick), .reg_rdata_out(rdata), .strobe_out(strobe), .strobe_oe_out(oe));
  // An undriven pin is biased to the inactive level, so it cannot fake a trigger.
  assign pin = oe ? strobe : pol;
  sfc_flash_model sfc_flash_model_i (.clk_in(clk_in), .pin_in(pin), .pol_in(pol), .fires_out(fires));
  always #4 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////
  // Every change is applied 1 ns after a rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step(1);
    req = '0;
    step(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    req = '0;
    step(1);
    chk(rdata, exp);
  endtask
  function automatic int lines(input int m, input int w);
    return (m == 0) ? w + 1 : ((m == 3) ? 5 : LEDN);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // A hang costs a mismatch and ends the run the usual way.
  initial
  begin
    #100000;
    err_total++;
    end_of_test();
  end
  // Main sequence: defaults, every mode and width, soft and hard reset.
  initial
  begin
    logic [7:0] v;
    int n;
    step(6);
    rstn_in = 1'b1;
    chk({7'h00, oe}, 8'h00);
    rd(16'h307A, 8'h00);
    rd(16'h1234, 8'h00);
    pol = 1'b1;
    wr(16'h307A, 8'h7F);
    rd(16'h307A, 8'h4F);
    chk({7'h00, strobe}, 8'h01);
    chk(8'(fires), 8'h00);
    wr(16'h30B1, 8'h10);
    chk({7'h00, oe}, 8'h01);
    $display("test registers done");
    for (int m = 0; m < 4; m++)
      for (int w = 0; w < 4; w++)
      begin
        v = 8'(($random(seed) & 32'h40) | (w << 2) | m);
        pol = v[6];
        wr(16'h307A, v);
        chk({7'h00, strobe}, {7'h00, pol});
        n = fires;
        wr(16'h307A, v | 8'h80);
        // A second arm while the pulse runs must not stretch or restart it.
        wr(16'h307A, v | 8'h80);
        for (int i = 0; i < lines(m, w); i++)
        begin
          step(1 + ($random(seed) & 32'h1));
          chk({7'h00, strobe}, {7'h00, ~pol});
          tick = 1'b1;
          step(1);
          tick = 1'b0;
        end
        step(2);
        chk({7'h00, strobe}, {7'h00, pol ^ (m == 3)});
        if (m == 3)
          wr(16'h307A, v);
        step(1);
        chk({7'h00, strobe}, {7'h00, pol});
        chk(8'(fires - n), 8'h01);
      end
    $display("test modes done");
    pol = 1'b0;
    wr(16'h307A, 8'h83);
    wr(16'h3012, 8'h80);
    step(1);
    chk({7'h00, strobe}, 8'h00);
    rd(16'h307A, 8'h00);
    rd(16'h30B1, 8'h10);
    rd(16'h3012, 8'h00);
    wr(16'h307A, 8'h83);
    rstn_in = 1'b0;
    step(2);
    rstn_in = 1'b1;
    chk({7'h00, strobe, oe}, 8'h00);
    rd(16'h307A, 8'h00);
    $display("test resets done");
    end_of_test();
  end
endmodule
